// *** design/hbrn_negotiator.sv ***
// Host port rate selection and trial-and-confirm rate negotiation
`timescale 1ns/1ps
`default_nettype none
`include "hbrn_map.svh"
// Operation
// R1: Sample rate pin at reset: low 9600, high 38400
// R2: Low-speed rate fixed; only high rate replaceable
// R3: Divisor parameter held in nonvolatile storage
// R4: Enabled stored divisor replaces high default
// R5: Bit rate is base rate over divisor
// R6: Commands write and enable/disable stored divisor
// R7: Written divisor applies only after full reset
// R8: Trial command answers OK, CR, optional LF
// R9: Switch to proposed rate, then settle wait
// R10: Then send identity string and CR
// R11: Host answers CR only on string match
// R12: CR in time keeps rate, sends OK; else revert
// R13: Host trusts new rate only after OK
// R14: Negotiated rate lasts until full reset
// R15: Settle and confirm timeout is programmable
// R16: Only a well-framed CR confirms the trial
module hbrn_negotiator #(
   parameter int CYC_PER_MS = `HBRN_CYC_PER_MS
) (
   // Clock and power-on reset
   input wire logic clk_i,
   input wire logic rst_i,
   // Pins
   input wire logic rate_sel_i,
   input wire logic external_reset_pin_n_i,
   // Commands from the parser, one-cycle pulses
   input wire logic full_reset_cmd_i,
   input wire logic restore_defaults_cmd_i,
   input wire logic warm_restart_cmd_i,
   input wire logic try_baud_divisor_cmd_i,
   input wire logic set_baud_trial_timeout_cmd_i,
   input wire logic param_wr_i,
   input wire logic param_on_i,
   input wire logic param_off_i,
   input wire logic [7:0] cmd_arg_i,
   input wire logic lf_en_i,
   // Nonvolatile store of the stored_baud_divisor_param
   input wire logic [7:0] nv_divisor_i,
   input wire logic nv_enable_i,
   output logic nv_div_we_o,
   output logic [7:0] nv_div_o,
   output logic nv_en_we_o,
   output logic nv_en_o,
   // Serial port byte interface
   input wire logic tx_ready_i,
   input wire logic tx_idle_i,
   output logic tx_valid_o,
   output logic [7:0] tx_data_o,
   input wire logic rx_valid_i,
   input wire hbrn_pkg::hbrn_rxb_s rx_i,
   // Rate and status
   output hbrn_pkg::hbrn_div_t baud_divisor_o,
   output logic bit_tick_o,
   output logic trial_busy_o,
   output logic trial_pass_o,
   output logic trial_fail_o
);
   import hbrn_pkg::*;
   localparam logic [16:0] MS_LAST = 17'(CYC_PER_MS - 1);

   // Character of the OK message (sel 0) or identity message (sel 1)
   function automatic logic [7:0] msg_char(input logic sel, input logic [3:0] idx);
      logic [7:0] id_str [0:8];
      // Arbitrary neutral identity text "HBRN v1.0"
      id_str = '{8'h48, 8'h42, 8'h52, 8'h4e, 8'h20, 8'h76, 8'h31, 8'h2e, 8'h30};
      if (sel) begin
         msg_char = (idx >= `HBRN_ID_LAST) ? `HBRN_CH_CR : id_str[idx];
      end else begin
         case (idx)
            4'h0: msg_char = `HBRN_CH_O;
            4'h1: msg_char = `HBRN_CH_K;
            4'h2: msg_char = `HBRN_CH_CR;
            default: msg_char = `HBRN_CH_LF;
         endcase
      end
   endfunction : msg_char

   // Index of the last character of a message
   function automatic logic [3:0] msg_last(input logic sel, input logic lf);
      msg_last = sel ? `HBRN_ID_LAST : (lf ? 4'h3 : 4'h2);
   endfunction : msg_last

   // ------------------------------------------------------------------------
   // Pin synchronisers
   // ------------------------------------------------------------------------
   logic sel_meta, rate_sel_q; // Rate select pin, two stages
   logic rstn_meta, ext_rst_n_q; // External reset pin, two stages

   // Two flip-flops before any use of the pins
   always_ff @(posedge clk_i) begin
      sel_meta <= rate_sel_i;
      rate_sel_q <= sel_meta;
      rstn_meta <= external_reset_pin_n_i;
      ext_rst_n_q <= rstn_meta;
   end

   // Power cycle, command or pin all give a full reset
   logic full_rst;
   assign full_rst = rst_i | full_reset_cmd_i | ~ext_rst_n_q;

   // ------------------------------------------------------------------------
   // Sequencer state
   // ------------------------------------------------------------------------
   hbrn_state_e state, next_state;
   logic [1:0] settle, next_settle; // Wait for synchronisers after a reset
   logic load_pend, next_load_pend; // Rate still to be sampled
   hbrn_div_t act_div, next_act_div; // Divisor in use
   hbrn_div_t old_div, next_old_div; // Divisor to revert to
   logic [7:0] trial_div, next_trial_div; // Proposed divisor
   logic [7:0] timeout_ms, next_timeout_ms; // Settle and confirm limit
   logic [7:0] ms_left, next_ms_left; // Remaining whole milliseconds
   logic [16:0] ms_cnt, next_ms_cnt; // Cycles within a millisecond
   logic [3:0] ptr, next_ptr; // Character index in message
   logic [7:0] next_tx_data;
   logic next_pass, next_fail, next_div_we, next_en_we, next_en;
   logic [7:0] next_nv_div;
   logic load_now, ms_tick, expire, sending, msg_sel, good_cr, restart;

   assign load_now = load_pend && (settle == `HBRN_SETTLE_CYC);
   assign ms_tick = (ms_cnt == MS_LAST);
   assign expire = (ms_left == 8'h00);
   assign sending = (state == ST_ACK) || (state == ST_ID) || (state == ST_ACK_NEW);
   assign msg_sel = (state == ST_ID);
   assign good_cr = rx_valid_i && (rx_i.data == `HBRN_CH_CR) && !rx_i.frame_err;

   // Next values of the sequencer
   always_comb begin
      next_state = state;
      next_settle = settle;
      next_load_pend = load_pend;
      next_act_div = act_div;
      next_old_div = old_div;
      next_trial_div = trial_div;
      next_timeout_ms = timeout_ms;
      next_ms_left = ms_left;
      next_ms_cnt = ms_tick ? 17'h00000 : ms_cnt + 17'h00001;
      next_ptr = ptr;
      next_pass = 1'b0;
      next_fail = 1'b0;
      next_div_we = 1'b0;
      next_en_we = 1'b0;
      next_en = nv_en_o;
      next_nv_div = nv_div_o;
      // Millisecond countdown while waiting
      if (ms_tick && !expire) begin
         next_ms_left = ms_left - 8'h01;
      end
      // Stored divisor goes straight to the nonvolatile store
      if (param_wr_i) begin
         next_div_we = 1'b1; // R3 R6
         next_nv_div = cmd_arg_i;
      end
      if (param_on_i || param_off_i) begin
         next_en_we = 1'b1; // R6
         next_en = param_on_i;
      end
      // Timeout setting, restored by the default and warm commands
      if (set_baud_trial_timeout_cmd_i) begin
         next_timeout_ms = cmd_arg_i; // R15
      end else if (restore_defaults_cmd_i || warm_restart_cmd_i) begin
         next_timeout_ms = `HBRN_TIMEOUT_MS_RST;
      end
      // Sample the rate pin once the synchronisers are settled
      if (load_pend) begin
         if (settle != `HBRN_SETTLE_CYC) begin
            next_settle = settle + 2'h1;
         end else begin
            next_load_pend = 1'b0;
            if (!rate_sel_q) begin
               next_act_div = `HBRN_DIV_LOW; // R1 R2
            end else if (nv_enable_i) begin
               next_act_div = {1'b0, nv_divisor_i}; // R4 R7
            end else begin
               next_act_div = `HBRN_DIV_HIGH; // R1 R4
            end
         end
      end
      case (state)
         // Accept a trial only when the rate is settled
         ST_IDLE: begin
            if (try_baud_divisor_cmd_i && !load_pend) begin
               next_trial_div = cmd_arg_i;
               next_old_div = act_div;
               next_ptr = 4'h0;
               next_state = ST_ACK; // R8
            end
         end
         // OK, CR and optional LF at the old rate, no prompt
         ST_ACK: begin
            if (tx_ready_i) begin
               if (ptr == msg_last(1'b0, lf_en_i)) begin
                  next_state = ST_DRAIN; // R8
               end else begin
                  next_ptr = ptr + 4'h1;
               end
            end
         end
         // Let the last bit leave before the rate changes
         ST_DRAIN: begin
            if (tx_idle_i) begin
               next_act_div = {1'b0, trial_div}; // R5 R9
               next_ms_left = timeout_ms; // R15
               next_ms_cnt = 17'h00000;
               next_state = ST_SETTLE; // R9
            end
         end
         // Idle at the new rate while the host retunes
         ST_SETTLE: begin
            if (expire) begin
               next_ptr = 4'h0;
               next_state = ST_ID; // R10
            end
         end
         // Identity string and CR at the new rate
         ST_ID: begin
            if (tx_ready_i) begin
               if (ptr == msg_last(1'b1, lf_en_i)) begin
                  next_state = ST_DRAIN_ID; // R10
               end else begin
                  next_ptr = ptr + 4'h1;
               end
            end
         end
         // Start the confirm window once the CR is out
         ST_DRAIN_ID: begin
            if (tx_idle_i) begin
               next_ms_left = timeout_ms; // R12 R15
               next_ms_cnt = 17'h00000;
               next_state = ST_CONFIRM;
            end
         end
         // A clean CR keeps the rate; anything else or time-out reverts
         ST_CONFIRM: begin
            if (good_cr) begin
               next_ptr = 4'h0;
               next_state = ST_ACK_NEW; // R12 R16
            end else if (rx_valid_i || expire) begin
               next_act_div = old_div; // R12 R16
               next_fail = 1'b1;
               next_state = ST_IDLE;
            end
         end
         // OK at the kept rate, which then lasts until a full reset
         ST_ACK_NEW: begin
            if (tx_ready_i) begin
               if (ptr == msg_last(1'b0, lf_en_i)) begin
                  next_pass = 1'b1; // R14
                  next_state = ST_IDLE;
               end else begin
                  next_ptr = ptr + 4'h1;
               end
            end
         end
         default: begin
            next_state = ST_IDLE;
         end
      endcase
      next_tx_data = msg_char(next_state == ST_ID, next_ptr);
      // Full reset abandons a trial and resamples the pin
      if (full_rst) begin
         next_state = ST_IDLE; // R7 R14
         next_load_pend = 1'b1;
         next_settle = 2'h0;
      end
   end

   // Register the sequencer; power reset also restores the timeout
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         state <= ST_IDLE;
         settle <= 2'h0;
         load_pend <= 1'b1;
         act_div <= `HBRN_DIV_HIGH;
         old_div <= `HBRN_DIV_HIGH;
         trial_div <= 8'h00;
         timeout_ms <= `HBRN_TIMEOUT_MS_RST;
         ms_left <= 8'h00;
         ms_cnt <= 17'h00000;
         ptr <= 4'h0;
         tx_data_o <= 8'h00;
         trial_pass_o <= 1'b0;
         trial_fail_o <= 1'b0;
         nv_div_we_o <= 1'b0;
         nv_div_o <= 8'h00;
         nv_en_we_o <= 1'b0;
         nv_en_o <= 1'b0;
      end else begin
         state <= next_state;
         settle <= next_settle;
         load_pend <= next_load_pend;
         act_div <= next_act_div;
         old_div <= next_old_div;
         trial_div <= next_trial_div;
         timeout_ms <= next_timeout_ms;
         ms_left <= next_ms_left;
         ms_cnt <= next_ms_cnt;
         ptr <= next_ptr;
         tx_data_o <= next_tx_data;
         trial_pass_o <= next_pass;
         trial_fail_o <= next_fail;
         nv_div_we_o <= next_div_we;
         nv_div_o <= next_nv_div;
         nv_en_we_o <= next_en_we;
         nv_en_o <= next_en;
      end
   end

   assign tx_valid_o = sending;
   assign trial_busy_o = (state != ST_IDLE);
   assign baud_divisor_o = act_div;
   assign restart = (act_div != next_act_div);

   // ------------------------------------------------------------------------
   // Bit rate generator
   // ------------------------------------------------------------------------
   hbrn_baud_gen u_baud_gen (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .restart_i(restart),
      .divisor_i(act_div),
      .bit_tick_o(bit_tick_o)
   );

   // ------------------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------------------
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);

   sequence s_good_cr;
      state == ST_CONFIRM && good_cr && !full_rst;
   endsequence
   sequence s_bad_rx;
      state == ST_CONFIRM && rx_valid_i && !good_cr && !full_rst;
   endsequence

   property p_low_sel;
      load_now && !rate_sel_q && !full_rst |=> act_div == `HBRN_DIV_LOW;
   endproperty
   a_low_sel: assert property (p_low_sel) else $error("low select not 9600"); // R1
   property p_high_def;
      load_now && rate_sel_q && !nv_enable_i && !full_rst |=> act_div == `HBRN_DIV_HIGH;
   endproperty
   a_high_def: assert property (p_high_def) else $error("high default wrong"); // R4
   property p_high_nv;
      load_now && rate_sel_q && nv_enable_i && !full_rst
         |=> act_div == {1'b0, $past(nv_divisor_i)};
   endproperty
   a_high_nv: assert property (p_high_nv) else $error("stored divisor not used"); // R4
   property p_idle_hold;
      state == ST_IDLE && !load_pend && !full_rst |=> $stable(act_div);
   endproperty
   a_idle_hold: assert property (p_idle_hold) else $error("rate moved while idle"); // R14
   property p_ack_first;
      state == ST_IDLE && try_baud_divisor_cmd_i && !load_pend && !full_rst
         |=> tx_valid_o && tx_data_o == `HBRN_CH_O;
   endproperty
   a_ack_first: assert property (p_ack_first) else $error("trial not answered OK"); // R8
   property p_switch;
      state == ST_DRAIN && tx_idle_i && !full_rst
         |=> state == ST_SETTLE && act_div == {1'b0, trial_div} && ms_left == $past(timeout_ms);
   endproperty
   a_switch: assert property (p_switch) else $error("rate not switched"); // R9
   property p_id_start;
      state == ST_SETTLE && expire && !full_rst
         |=> tx_valid_o && tx_data_o == msg_char(1'b1, 4'h0);
   endproperty
   a_id_start: assert property (p_id_start) else $error("identity not sent"); // R10
   property p_accept;
      s_good_cr |=> state == ST_ACK_NEW && tx_valid_o && tx_data_o == `HBRN_CH_O;
   endproperty
   a_accept: assert property (p_accept) else $error("clean CR not accepted"); // R12
   property p_reject;
      s_bad_rx |=> state == ST_IDLE && act_div == $past(old_div) && trial_fail_o;
   endproperty
   a_reject: assert property (p_reject) else $error("bad char kept rate"); // R16
   property p_timeout_set;
      set_baud_trial_timeout_cmd_i |=> timeout_ms == $past(cmd_arg_i);
   endproperty
   a_timeout_set: assert property (p_timeout_set) else $error("timeout not set"); // R15
   // Default and warm commands put the trial limit back to its reset value
   property p_timeout_rst;
      (restore_defaults_cmd_i || warm_restart_cmd_i) && !set_baud_trial_timeout_cmd_i
         |=> timeout_ms == `HBRN_TIMEOUT_MS_RST;
   endproperty
   a_timeout_rst: assert property (p_timeout_rst) else $error("timeout not restored"); // R15
endmodule : hbrn_negotiator
`default_nettype wire

// *** design/hbrn_map.svh ***
// Constants for host baud rate negotiation: rates, divisors, characters, timing
`ifndef HBRN_MAP_SVH
`define HBRN_MAP_SVH
// ----------------------------------------------------------------------------
// Clock and base rate
// ----------------------------------------------------------------------------
`define HBRN_CLK_FREQ_KHZ 100000
`define HBRN_BASE_RATE_KBPS 4000
`define HBRN_BASE_CYC (`HBRN_CLK_FREQ_KHZ / `HBRN_BASE_RATE_KBPS)
`define HBRN_CYC_PER_MS (`HBRN_CLK_FREQ_KHZ)
// ----------------------------------------------------------------------------
// Divisors of the base rate (9600 and 38400 rounded to whole divisors)
// ----------------------------------------------------------------------------
`define HBRN_DIV_LOW 9'h1a1
`define HBRN_DIV_HIGH 9'h068
// ----------------------------------------------------------------------------
// Trial timing and reset values
// ----------------------------------------------------------------------------
`define HBRN_TIMEOUT_MS_RST 8'h4b
`define HBRN_SETTLE_CYC 2'h3
// ----------------------------------------------------------------------------
// Characters and message layout
// ----------------------------------------------------------------------------
`define HBRN_CH_O 8'h4f
`define HBRN_CH_K 8'h4b
`define HBRN_CH_CR 8'h0d
`define HBRN_CH_LF 8'h0a
`define HBRN_ID_LAST 4'h9
`endif

// *** design/hbrn_pkg.sv ***
// Types shared by the host baud rate negotiation block
package hbrn_pkg;
   // Negotiation sequencer states
   typedef enum logic [2:0] {
      ST_IDLE, ST_ACK, ST_DRAIN, ST_SETTLE, ST_ID, ST_DRAIN_ID, ST_CONFIRM, ST_ACK_NEW
   } hbrn_state_e;
   // One received character with its framing status
   typedef struct packed {
      logic [7:0] data;
      logic frame_err;
   } hbrn_rxb_s;
   // Divisor value carried inside the block
   typedef logic [8:0] hbrn_div_t;
endpackage : hbrn_pkg

// *** design/hbrn_baud_gen.sv ***
// Bit rate tick generator: base rate divided by the active divisor
`timescale 1ns/1ps
`default_nettype none
`include "hbrn_map.svh"
module hbrn_baud_gen (
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // Control
   input wire logic restart_i,
   input wire hbrn_pkg::hbrn_div_t divisor_i,
   // Tick out
   output logic bit_tick_o
);
   import hbrn_pkg::*;
   localparam logic [4:0] BASE_LAST = 5'(`HBRN_BASE_CYC - 1);

   // A zero divisor would wrap to a 512-period bit; treat it as one
   function automatic hbrn_div_t clamp_div(input hbrn_div_t d);
      clamp_div = (d == 9'h000) ? 9'h001 : d;
   endfunction : clamp_div

   logic [4:0] base_cnt; // Cycles within one base period
   logic [4:0] next_base_cnt;
   hbrn_div_t bit_cnt; // Base periods within one bit
   hbrn_div_t next_bit_cnt;
   logic next_tick;

   // ------------------------------------------------------------------------
   // Divider chain
   // ------------------------------------------------------------------------
   // Next values of both counters
   always_comb begin
      next_base_cnt = base_cnt + 5'h01;
      next_bit_cnt = bit_cnt;
      next_tick = 1'b0;
      if (restart_i) begin
         next_base_cnt = 5'h00;
         next_bit_cnt = 9'h000;
      end else if (base_cnt == BASE_LAST) begin
         next_base_cnt = 5'h00;
         if (bit_cnt >= clamp_div(divisor_i) - 9'h001) begin // R5
            next_bit_cnt = 9'h000;
            next_tick = 1'b1;
         end else begin
            next_bit_cnt = bit_cnt + 9'h001;
         end
      end
   end

   // Register the counters
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         base_cnt <= 5'h00;
         bit_cnt <= 9'h000;
         bit_tick_o <= 1'b0;
      end else begin
         base_cnt <= next_base_cnt;
         bit_cnt <= next_bit_cnt;
         bit_tick_o <= next_tick;
      end
   end
endmodule : hbrn_baud_gen
`default_nettype wire

// *** verification/hbrn_host_model.sv ***
// Host side model: byte sink that checks the identity text and answers
`timescale 1ns/1ps
`default_nettype none
module hbrn_host_model #(
   parameter logic [71:0] ID_TEXT = "HBRN v1.0" // Arbitrary identity text
) (
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // Reply kind: 0 silent, 1 CR, 2 other char, 3 badly framed CR
   input wire logic [1:0] mode_i,
   input wire logic slow_i,
   // Byte link with the block
   input wire logic tx_valid_i,
   input wire logic [7:0] tx_data_i,
   output logic tx_ready_o,
   output logic tx_idle_o,
   output logic rx_valid_o,
   output hbrn_pkg::hbrn_rxb_s rx_o
);
   import hbrn_pkg::*;
   logic [79:0] last; // Last ten bytes taken
   logic [2:0] busy; // Shifter time left
   logic [4:0] wait_cnt; // Reply delay
   logic phase; // Stall pattern when slow
   logic [7:0] junk; // Moving idle pattern
   logic take; // Byte accepted this cycle
   assign tx_ready_o = !slow_i || phase;
   assign tx_idle_o = (busy == 3'h0);
   assign take = tx_valid_i && tx_ready_o;
   // Take bytes, compare identity, schedule the reply
   always @(posedge clk_i) begin
      if (rst_i) begin
         phase <= 1'b0;
         junk <= 8'h00;
         busy <= 3'h0;
         wait_cnt <= 5'h00;
         last <= '0;
         rx_valid_o <= 1'b0;
      end else begin
         phase <= !phase;
         junk <= junk + 8'h35;
         if (wait_cnt == 5'h01 && mode_i != 2'h0) begin
            rx_valid_o <= 1'b1;
            rx_o <= '{data: (mode_i == 2'h2) ? 8'h78 : 8'h0d, frame_err: (mode_i == 2'h3)};
         end else begin
            rx_valid_o <= 1'b0;
            rx_o <= '{data: junk, frame_err: junk[0]};
         end
         if (take) last <= {last[71:0], tx_data_i};
         if (take) busy <= 3'h5;
         else if (busy != 3'h0) busy <= busy - 3'h1;
         if (take && tx_data_i == 8'h0d && last[71:0] == ID_TEXT) wait_cnt <= 5'h14;
         else if (wait_cnt != 5'h00) wait_cnt <= wait_cnt - 5'h01;
      end
   end
endmodule : hbrn_host_model
`default_nettype wire

// *** verification/host_baud_rate_negotiation_test.sv ***
// Self-checking bench for the host rate negotiation block
`timescale 1ns/1ps
`default_nettype none
module host_baud_rate_negotiation_test;
   import hbrn_pkg::*;
   localparam int CYC = 20; // Short millisecond
   localparam logic [71:0] ID_TEXT = "HBRN v1.0"; // Arbitrary identity text
   typedef struct packed {logic sel; logic en; logic [7:0] nv; logic [8:0] div;} hbrn_row_s;
   hbrn_row_s rows [4] = '{'{0, 0, 8'h45, 9'h1a1}, '{0, 1, 8'h45, 9'h1a1},
      '{1, 1, 8'h45, 9'h045}, '{1, 0, 8'h45, 9'h068}};
   logic [1:0] modes [4] = '{2'h0, 2'h2, 2'h3, 2'h1};
   logic clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic rate_sel = 1'b0;
   logic pin_n = 1'b1;
   logic lf_en = 1'b0;
   logic [7:0] cmd = 8'h00; // One bit per command pulse
   logic [7:0] arg = 8'h00;
   logic [7:0] nv_div; // Nonvolatile store contents
   logic nv_en;
   hbrn_row_s row; // Store contents loaded while in reset
   logic [1:0] mode = 2'h0;
   logic slow = 1'b0;
   logic nv_div_we, nv_en_we, nv_en_w, tx_ready, tx_idle, tx_valid, rx_valid;
   logic tick, busy, pass, fail;
   logic [7:0] nv_div_w, tx_data;
   hbrn_rxb_s rx;
   hbrn_div_t div, div_at_id;
   logic [7:0] seen [$];
   logic [7:0] exp [$];
   int cycles = 0;
   int pass_cnt = 0;
   int fail_cnt = 0;
   int miscompares = 0;
   int check_count = 0;
   always #5 clk_i = ~clk_i;
   hbrn_negotiator #(.CYC_PER_MS(CYC)) i_hbrn_negotiator (.clk_i(clk_i), .rst_i(rst_i),
      .rate_sel_i(rate_sel), .external_reset_pin_n_i(pin_n), .full_reset_cmd_i(cmd[0]),
      .restore_defaults_cmd_i(cmd[1]), .warm_restart_cmd_i(cmd[2]),
      .try_baud_divisor_cmd_i(cmd[3]), .set_baud_trial_timeout_cmd_i(cmd[4]),
      .param_wr_i(cmd[5]), .param_on_i(cmd[6]), .param_off_i(cmd[7]), .cmd_arg_i(arg),
      .lf_en_i(lf_en), .nv_divisor_i(nv_div), .nv_enable_i(nv_en), .nv_div_we_o(nv_div_we),
      .nv_div_o(nv_div_w), .nv_en_we_o(nv_en_we), .nv_en_o(nv_en_w), .tx_ready_i(tx_ready),
      .tx_idle_i(tx_idle), .tx_valid_o(tx_valid), .tx_data_o(tx_data), .rx_valid_i(rx_valid),
      .rx_i(rx), .baud_divisor_o(div), .bit_tick_o(tick), .trial_busy_o(busy),
      .trial_pass_o(pass), .trial_fail_o(fail));
   hbrn_host_model #(.ID_TEXT(ID_TEXT)) i_hbrn_host_model (.clk_i(clk_i), .rst_i(rst_i),
      .mode_i(mode), .slow_i(slow), .tx_valid_i(tx_valid), .tx_data_i(tx_data),
      .tx_ready_o(tx_ready), .tx_idle_o(tx_idle), .rx_valid_o(rx_valid), .rx_o(rx));
   // Monitor: NV store, sent bytes, trial outcomes and the hang limit
   always @(posedge clk_i) begin
      cycles <= cycles + 1;
      if (rst_i) begin
         nv_div <= row.nv;
         nv_en <= row.en;
      end else begin
         if (nv_div_we) nv_div <= nv_div_w;
         if (nv_en_we) nv_en <= nv_en_w;
      end
      if (tx_valid && tx_ready) seen.push_back(tx_data);
      if (tx_valid && tx_ready && tx_data == 8'h48) div_at_id <= div;
      if (pass === 1'b1) pass_cnt <= pass_cnt + 1;
      if (fail === 1'b1) fail_cnt <= fail_cnt + 1;
      if (cycles == 30000) begin
         miscompares++;
         give_verdict();
      end
   end
   task automatic check_val(input string what, input logic [15:0] e, input logic [15:0] g);
      check_count++;
      if (g !== e) begin
         miscompares++;
         $display("wrong value %s expected %h seen %h", what, e, g);
      end
   endtask : check_val
   task automatic pulse(input int b, input logic [7:0] a);
      @(posedge clk_i);
      cmd <= 8'h01 << b;
      arg <= a;
      @(posedge clk_i);
      cmd <= 8'h00;
   endtask : pulse
   task automatic give_verdict();
      $display("checks %0d mismatches %0d", check_count, miscompares);
      if (miscompares == 0 && check_count > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask : give_verdict
   // Main sequence
   initial begin
      int n;
      int ok;
      int p;
      // Rate chosen at reset from pin and stored divisor
      foreach (rows[r]) begin
         rate_sel <= rows[r].sel;
         row <= rows[r];
         rst_i <= 1'b1;
         repeat (8) @(posedge clk_i);
         rst_i <= 1'b0;
         repeat (10) @(posedge clk_i);
         check_val("rate at reset", rows[r].div, div);
      end
      // Bit period of the 38400 default
      n = 0;
      while (tick !== 1'b1 && n < 3000) begin
         @(posedge clk_i);
         n++;
      end
      n = 0;
      do begin
         @(posedge clk_i);
         n++;
      end while (tick !== 1'b1 && n < 3000);
      check_val("bit period", 16'd2600, 16'(n));
      // Trials with every host reply kind, a refused second request each time
      pulse(4, 8'h03);
      foreach (modes[k]) begin
         mode <= modes[k];
         slow <= modes[k][1];
         lf_en <= modes[k][0];
         ok = (modes[k] == 2'h1);
         seen.delete();
         exp.delete();
         n = pass_cnt + fail_cnt;
         p = pass_cnt;
         pulse(3, 8'h45);
         pulse(3, 8'h10);
         check_val("busy in trial", 1'b1, busy);
         while (pass_cnt + fail_cnt == n && cycles < 29000) @(posedge clk_i);
         repeat (3) @(posedge clk_i);
         check_val("busy after trial", 1'b0, busy);
         check_val("trial kept", 16'(ok), 16'(pass_cnt - p));
         check_val("trial rate", 9'h045, div_at_id);
         check_val("rate after trial", ok ? 9'h045 : 9'h068, div);
         for (int j = 0; j <= ok; j++) begin
            exp.push_back(8'h4f);
            exp.push_back(8'h4b);
            exp.push_back(8'h0d);
            if (modes[k][0]) exp.push_back(8'h0a);
            for (int i = 8; i >= 0 && j == 0; i--) exp.push_back(ID_TEXT[i*8 +: 8]);
            if (j == 0) exp.push_back(8'h0d);
         end
         check_val("byte count", 16'(exp.size()), 16'(seen.size()));
         foreach (exp[i]) check_val("byte", exp[i], seen[i]);
      end
      // Negotiated rate survives soft commands, not a full reset
      pulse(1, 8'h00);
      pulse(2, 8'h00);
      repeat (5) @(posedge clk_i);
      check_val("rate after soft", 9'h045, div);
      pulse(0, 8'h00);
      repeat (10) @(posedge clk_i);
      check_val("rate after full", 9'h068, div);
      // Stored divisor write, enable, then reset pin
      pulse(5, 8'h50);
      pulse(6, 8'h00);
      repeat (3) @(posedge clk_i);
      check_val("stored divisor", 8'h50, nv_div);
      check_val("stored enable", 1'b1, nv_en);
      check_val("rate before reset", 9'h068, div);
      pin_n <= 1'b0;
      repeat (4) @(posedge clk_i);
      pin_n <= 1'b1;
      repeat (12) @(posedge clk_i);
      check_val("rate after pin", 9'h050, div);
      pulse(7, 8'h00);
      pulse(0, 8'h00);
      repeat (10) @(posedge clk_i);
      check_val("stored enable", 1'b0, nv_en);
      check_val("rate disabled", 9'h068, div);
      give_verdict();
   end
endmodule : host_baud_rate_negotiation_test
`default_nettype wire
